// ---- design/boundary_scan_test_port.sv ----
`timescale 1ns/1ps
`include "tap_consts.svh"

module boundary_scan_test_port (
    input  wire logic  i_clk_sys,
    input  wire logic  i_reset_n,
    input  wire logic  i_tck,
    input  wire logic  i_tms,
    input  wire logic  i_tdi,
    input  wire logic  i_trst_n,
    input  wire logic  i_tms_connected,
    input  wire logic  i_tdi_connected,
    input  wire logic  i_trst_connected,
    output logic       o_tdo,
    output logic       o_tdo_oe,
    output logic       o_fifo_data_oe,
    output logic       o_tap_reset_state
);
    import tap_pkg::*;

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    scan_pins_t   pins;
    scan_events_t ev;
    tap_state_t   state;

    always_comb begin
        pins.tck    = i_tck;
        pins.tms    = i_tms_connected ? i_tms : 1'b1;
        pins.tdi    = i_tdi_connected ? i_tdi : 1'b1;
        pins.trst_n = i_trst_connected ? i_trst_n : 1'b1;
    end

    scan_pin_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_pins    (pins),
        .o_events  (ev)
    );

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    // Sampling on ev.rise keeps all test action except the TRST override tied to TCK edges
    tap_fsm u_fsm (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_trst_n  (ev.trst_n),
        .i_step    (ev.rise),
        .i_tms     (ev.tms),
        .o_state   (state)
    );

    // ------------------------------------------------------------
    // Scan registers
    // ------------------------------------------------------------
    logic [`IR_WIDTH-1:0] ir_shift;
    logic [`IR_WIDTH-1:0] ir;
    logic [`ID_WIDTH-1:0] id_shift;
    logic                 bypass;
    logic                 tap_was_reset;
    logic                 tdo;
    logic                 tdo_oe;
    logic [`IR_WIDTH-1:0] next_ir_shift;
    logic [`IR_WIDTH-1:0] next_ir;
    logic [`ID_WIDTH-1:0] next_id_shift;
    logic                 next_bypass;
    logic                 next_tap_was_reset;
    logic                 next_tdo;
    logic                 next_tdo_oe;

    function automatic logic select_id(input logic [`IR_WIDTH-1:0] op);
        select_id = (op == `IR_OP_IDCODE);
    endfunction

    always_comb begin
        next_ir_shift      = ir_shift;
        next_ir            = ir;
        next_id_shift      = id_shift;
        next_bypass        = bypass;
        next_tap_was_reset = tap_was_reset;
        next_tdo           = tdo;
        next_tdo_oe        = tdo_oe;
        // Reset seen through system reset, TRST or five high TMS edges
        if (state == TEST_LOGIC_RESET) begin
            next_ir            = `IR_RESET_VALUE;
            next_tap_was_reset = 1'b1;
        end
        if (ev.rise) begin
            case (state)
                CAPTURE_IR: next_ir_shift = `IR_CAPTURE;
                SHIFT_IR:   next_ir_shift = {ev.tdi, ir_shift[`IR_WIDTH-1:1]};
                UPDATE_IR:  next_ir = ir_shift;
                CAPTURE_DR: begin
                    next_id_shift = `ID_VALUE;
                    next_bypass   = 1'b0;
                end
                SHIFT_DR: begin
                    if (select_id(ir)) begin
                        next_id_shift = {ev.tdi, id_shift[`ID_WIDTH-1:1]};
                    end else begin
                        next_bypass = ev.tdi;
                    end
                end
                default: ;
            endcase
        end
        if (ev.fall) begin
            next_tdo_oe = (state == SHIFT_DR) || (state == SHIFT_IR);
            if (state == SHIFT_IR) begin
                next_tdo = ir_shift[0];
            end else if (select_id(ir)) begin
                next_tdo = id_shift[0];
            end else begin
                next_tdo = bypass;
            end
        end
        // A TRST pulse may land between TCK edges; release TDO at once
        if (!ev.trst_n) begin
            next_tdo_oe = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ir_shift          <= `IR_RESET_VALUE;
            ir                <= `IR_RESET_VALUE;
            id_shift          <= `ID_VALUE;
            bypass            <= 1'b0;
            tap_was_reset     <= 1'b0;
            tdo               <= 1'b0;
            tdo_oe            <= 1'b0;
            o_tdo             <= 1'b0;
            o_tdo_oe          <= 1'b0;
            o_fifo_data_oe    <= 1'b0;
            o_tap_reset_state <= 1'b0;
        end else begin
            ir_shift          <= next_ir_shift;
            ir                <= next_ir;
            id_shift          <= next_id_shift;
            bypass            <= next_bypass;
            tap_was_reset     <= next_tap_was_reset;
            tdo               <= next_tdo;
            tdo_oe            <= next_tdo_oe;
            o_tdo             <= next_tdo;
            o_tdo_oe          <= next_tdo_oe;
            o_fifo_data_oe    <= next_tap_was_reset;
            o_tap_reset_state <= (state == TEST_LOGIC_RESET);
        end
    end
endmodule

// ---- design/tap_consts.svh ----
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// Instruction register
`define IR_WIDTH          4
`define IR_CAPTURE        4'h1
`define IR_OP_EXTEST      4'h0
`define IR_OP_IDCODE      4'h2
`define IR_OP_BYPASS      4'hF
`define IR_RESET_VALUE    4'h2

// Identification register, value arbitrary
`define ID_WIDTH          32
`define ID_VALUE          32'h1234_5679

// Consecutive high TMS edges that force Test-Logic-Reset
`define TMS_RESET_EDGES   5
`endif

// ---- design/tap_pkg.sv ----
package tap_pkg;
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } scan_pins_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
        logic trst_n;
    } scan_events_t;
endpackage

// ---- design/scan_pin_sync.sv ----
`timescale 1ns/1ps
`include "tap_consts.svh"

module scan_pin_sync (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset_n,
    input  wire tap_pkg::scan_pins_t   i_pins,
    output tap_pkg::scan_events_t      o_events
);
    import tap_pkg::*;

    scan_pins_t   stage1;
    scan_pins_t   stage2;
    scan_pins_t   stage3;
    scan_pins_t   stable;
    scan_pins_t   next_stable;
    scan_events_t next_events;

    // A pin counts as changed once stages two and three agree
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            next_stable[b] = (stage2[b] == stage3[b]) ? stage2[b] : stable[b];
        end
        next_events.rise   = next_stable.tck & ~stable.tck;
        next_events.fall   = ~next_stable.tck & stable.tck;
        next_events.tms    = next_stable.tms;
        next_events.tdi    = next_stable.tdi;
        next_events.trst_n = next_stable.trst_n;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            // Idle pin levels (TCK low, others high) so no false edge follows reset
            stage1   <= 4'h7;
            stage2   <= 4'h7;
            stage3   <= 4'h7;
            stable   <= 4'h7;
            o_events <= 5'h07;
        end else begin
            stage1   <= i_pins;
            stage2   <= stage1;
            stage3   <= stage2;
            stable   <= next_stable;
            o_events <= next_events;
        end
    end
endmodule

// ---- design/tap_fsm.sv ----
`timescale 1ns/1ps

module tap_fsm (
    input  wire logic                i_clk_sys,
    input  wire logic                i_reset_n,
    input  wire logic                i_trst_n,
    input  wire logic                i_step,
    input  wire logic                i_tms,
    output tap_pkg::tap_state_t      o_state
);
    import tap_pkg::*;

    tap_state_t next_state;

    always_comb begin
        next_state = o_state;
        if (i_step) begin
            case (o_state)
                TEST_LOGIC_RESET: next_state = i_tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
                RUN_TEST_IDLE:    next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
                SELECT_DR:        next_state = i_tms ? SELECT_IR : CAPTURE_DR;
                CAPTURE_DR:       next_state = i_tms ? EXIT1_DR : SHIFT_DR;
                SHIFT_DR:         next_state = i_tms ? EXIT1_DR : SHIFT_DR;
                EXIT1_DR:         next_state = i_tms ? UPDATE_DR : PAUSE_DR;
                PAUSE_DR:         next_state = i_tms ? EXIT2_DR : PAUSE_DR;
                EXIT2_DR:         next_state = i_tms ? UPDATE_DR : SHIFT_DR;
                UPDATE_DR:        next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
                SELECT_IR:        next_state = i_tms ? TEST_LOGIC_RESET : CAPTURE_IR;
                CAPTURE_IR:       next_state = i_tms ? EXIT1_IR : SHIFT_IR;
                SHIFT_IR:         next_state = i_tms ? EXIT1_IR : SHIFT_IR;
                EXIT1_IR:         next_state = i_tms ? UPDATE_IR : PAUSE_IR;
                PAUSE_IR:         next_state = i_tms ? EXIT2_IR : PAUSE_IR;
                EXIT2_IR:         next_state = i_tms ? UPDATE_IR : SHIFT_IR;
                UPDATE_IR:        next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
                default:          next_state = TEST_LOGIC_RESET;
            endcase
        end
    end

    // TRST overrides the edge step regardless of TCK
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || !i_trst_n) begin
            o_state <= TEST_LOGIC_RESET;
        end else begin
            o_state <= next_state;
        end
    end
endmodule

// ---- sim/tap_assertions.sv ----
`timescale 1ns/1ps
module tap_assertions (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    input wire logic i_tms_connected,
    input wire logic i_tdi_connected,
    input wire logic i_trst_connected,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic o_fifo_data_oe,
    input wire logic o_tap_reset_state
);
    // Pin view: the design sees each edge a few clocks later
    logic       tck_d;
    logic [2:0] ones;
    wire        trst_on = i_trst_connected & ~i_trst_n;
    wire        rise    = i_tck & ~tck_d;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    always_ff @(posedge i_clk_sys) begin
        tck_d <= i_tck;
        if (!i_reset_n || (rise && i_tms_connected && !i_tms)) begin
            ones <= 3'h0;
        end else if (rise && ones != 3'h5) begin
            ones <= ones + 3'h1;
        end
    end
    sequence s_trst_held; trst_on [*7]; endsequence
    sequence s_tck_high; i_tck [*4]; endsequence
    sequence s_tck_idle; (!i_tck && !trst_on) [*8]; endsequence
    a_trst_forces_tlr: assert property (s_trst_held |-> o_tap_reset_state && !o_tdo_oe)
        else $error("trst ignored");
    a_tdo_steady_high: assert property (s_tck_high |-> $stable(o_tdo) && $stable(o_tdo_oe))
        else $error("tdo moved in tck high");
    a_tdo_needs_tck: assert property (s_tck_idle |=> $stable(o_tdo) && $stable(o_tdo_oe))
        else $error("tdo moved without tck");
    a_five_ones_reset: assert property ($rose(ones == 3'h5) |-> ##[1:8] o_tap_reset_state)
        else $error("five high tms missed");
    a_reset_no_drive: assert property (o_tap_reset_state [*3] |-> !o_tdo_oe)
        else $error("tdo driven in reset state");
    a_fifo_oe_sticky: assert property (o_fifo_data_oe |=> o_fifo_data_oe)
        else $error("fifo enable dropped");
    a_fifo_oe_cause: assert property ($rose(o_fifo_data_oe) |->
        o_tap_reset_state || $past(o_tap_reset_state)) else $error("fifo enable early");
    a_reset_opens_fifo: assert property (o_tap_reset_state |-> ##[0:4] o_fifo_data_oe)
        else $error("fifo enable late");
endmodule

// ---- sim/scan_tester.sv ----
`timescale 1ns/1ps
module scan_tester (
    input  wire logic i_clk_sys,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe,
    output logic      o_tck    = 1'b0,
    output logic      o_tms    = 1'b1,
    output logic      o_tdi    = 1'b0,
    output logic      o_trst_n = 1'b1
);
    // TDO is read mid-high, since the design answers a fall several clocks late
    task automatic pulse(input logic tms, input logic tdi, output logic tdo, output logic oe);
        @(negedge i_clk_sys);
        o_tms = tms;
        o_tdi = tdi;
        o_tck = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        tdo = i_tdo;
        oe  = i_tdo_oe;
        repeat (2) @(negedge i_clk_sys);
        o_tck = 1'b0;
        o_tdi = ~tdi;
        repeat (3) @(negedge i_clk_sys);
    endtask
    task automatic reset_pin();
        @(negedge i_clk_sys);
        o_trst_n = 1'b0;
        repeat (8) @(negedge i_clk_sys);
        o_trst_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
    endtask
endmodule

// ---- sim/boundary_scan_test_port_test.sv ----
`timescale 1ns/1ps
`include "tap_consts.svh"
module boundary_scan_test_port_test;
    logic        i_clk_sys = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        tms_con = 1'b1, tdi_con = 1'b1, trst_con = 1'b1;
    wire         tck, tms, tdi, trst_n, tdo, tdo_oe, fifo_oe, tlr;
    wire         tdo_pin = tdo_oe ? tdo : 1'bz;
    int          fail_count = 0, samples_checked = 0, st = 0, ln = 1;
    int          seed = 32'hBD5A;
    // Next controller state for TMS low and high
    int          nx0[16] = '{1,1,3,4,4,6,6,4,1,10,11,11,13,13,11,1};
    int          nx1[16] = '{0,2,9,5,5,8,7,8,2,0,12,12,15,14,15,2};
    logic [3:0]  ir = `IR_RESET_VALUE;
    logic [3:0]  ops[4];
    logic [31:0] sh = 32'h0;
    logic [1:0]  q[$];
    always #50 i_clk_sys = ~i_clk_sys;
    boundary_scan_test_port i_boundary_scan_test_port (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_n(trst_n), .i_tms_connected(tms_con),
        .i_tdi_connected(tdi_con), .i_trst_connected(trst_con), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .o_fifo_data_oe(fifo_oe), .o_tap_reset_state(tlr));
    scan_tester i_scan_tester (.i_clk_sys(i_clk_sys), .i_tdo(tdo_pin), .i_tdo_oe(tdo_oe),
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input logic m, input logic d);
        logic so, soe, t, b;
        logic [1:0] e;
        t = m | ~tms_con;
        b = d | ~tdi_con;
        i_scan_tester.pulse(m, d, so, soe);
        e = q.pop_front();
        check({soe, soe & so}, {e[1], e[1] & e[0]});
        if (st == 3) begin
            ln = (ir == `IR_OP_IDCODE) ? `ID_WIDTH : 1;
            sh = (ir == `IR_OP_IDCODE) ? `ID_VALUE : 32'h0;
        end else if (st == 10) begin
            ln = `IR_WIDTH;
            sh = `IR_CAPTURE;
        end else if (st == 4 || st == 11) begin
            sh = (sh >> 1) | (32'(b) << (ln - 1));
        end
        st = t ? nx1[st] : nx0[st];
        if (st == 15) ir = sh[3:0];
        if (st == 0) ir = `IR_RESET_VALUE;
        q.push_back({st == 4 || st == 11, sh[0]});
        check({fifo_oe, tlr}, {1'b1, st == 0});
    endtask
    task automatic run(input logic [7:0] t, input int n);
        for (int i = 0; i < n; i++) step(t[i], 1'($random(seed)));
    endtask
    task automatic frame(input logic [7:0] pre, input int np, input int n,
                         input logic [31:0] data, input logic [7:0] post, input int nq);
        run(pre, np);
        for (int i = 0; i < n; i++) step(i == n - 1, data[i]);
        run(post, nq);
    endtask
    initial begin
        q.push_back(2'h0);
        ops = '{`IR_OP_BYPASS, `IR_OP_EXTEST, `IR_OP_IDCODE, 4'($random(seed))};
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        check({fifo_oe, tlr, tdo_oe}, 3'h6);
        run(8'h00, 1);
        frame(8'h01, 3, 32, $random(seed), 8'h1A, 6);
        for (int k = 0; k < 4; k++) begin
            frame(8'h03, 4, 4, 32'(ops[k]), 8'h06, 4);
            frame(8'h01, 3, 20, $random(seed), 8'h1A, 6);
        end
        run(8'h01, 3);
        run(8'h1F, 5);
        run(8'h00, 1);
        tms_con = 1'b0;
        run(8'h00, 5);
        tms_con = 1'b1;
        tdi_con = 1'b0;
        run(8'h00, 1);
        frame(8'h03, 4, 4, 32'h0, 8'h06, 4);
        frame(8'h01, 3, 8, 32'h0, 8'h1A, 6);
        tdi_con = 1'b1;
        run(8'h01, 3);
        trst_con = 1'b0;
        i_scan_tester.reset_pin();
        run(8'h00, 2);
        trst_con = 1'b1;
        i_scan_tester.reset_pin();
        st = 0;
        ir = `IR_RESET_VALUE;
        q = '{2'h0};
        check({tlr, tdo_oe}, 2'h2);
        run(8'h00, 1);
        frame(8'h01, 3, 8, $random(seed), 8'h1A, 6);
        summarize();
    end
    initial begin
        #500000;
        fail_count++;
        summarize();
    end
endmodule
bind boundary_scan_test_port tap_assertions i_tap_assertions (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_tck(i_tck), .i_tms(i_tms),
    .i_tdi(i_tdi), .i_trst_n(i_trst_n), .i_tms_connected(i_tms_connected),
    .i_tdi_connected(i_tdi_connected), .i_trst_connected(i_trst_connected),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_fifo_data_oe(o_fifo_data_oe),
    .o_tap_reset_state(o_tap_reset_state));
